// ===== verilog/sod_cfg.svh
/*
 Constants of the setup options decoder: field positions, reset values and timing counts.
 Assumes it is included by bare name from every file that needs a constant.
*/
`ifndef SOD_CFG_SVH
`define SOD_CFG_SVH
`define SOD_B3_RST 8'h01
`define SOD_B4_RST 8'h80
`define SOD_B3_MASK 8'h37
`define SOD_B4_MASK 8'hc7
`define SOD_B3_CONT 5
`define SOD_B3_LIMDIS 4
`define SOD_B3_ECHO 2
`define SOD_B3_DLY_HI 1
`define SOD_B3_DLY_LO 0
`define SOD_B4_DIG_HI 7
`define SOD_B4_DIG_LO 6
`define SOD_B4_MANDIS 2
`define SOD_B4_MODE_HI 1
`define SOD_B4_MODE_LO 0
`define SOD_DIN_RST 3'h7
`define SOD_ASCII_CR 8'h0d
`define SOD_ASCII_LF 8'h0a
`define SOD_CLK_HZ 200000000
`define SOD_BAUD_MAX 38400
`define SOD_CHAR_BITS 10
`define SOD_BASE_DIV (`SOD_CLK_HZ / `SOD_BAUD_MAX)
`define SOD_DIGITS 7
`define SOD_FIFO_DEPTH 4
`endif

// ===== verilog/sod_pkg.sv
/*
 Types of the setup options decoder.
 Assumes nothing of its surroundings.
*/
package sod_pkg;
	typedef enum logic [1:0] {
		SOD_MAN_UPDOWN = 2'b00,
		SOD_MAN_CTRL = 2'b01,
		SOD_MAN_LIM_NO = 2'b10,
		SOD_MAN_LIM_NC = 2'b11
	} sod_manual_e;
	typedef logic [7:0] sod_byte_t;
endpackage : sod_pkg

// ===== verilog/sod_fifo.sv
/*
 Small synchronous FIFO with valid and ready on both sides and registered flags.
 Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sod_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
			$error("sod_fifo depth must be a power of two of at least two");
		end
	endgenerate
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic ready_ff;
	logic valid_ff;
	wire push = in_valid && ready_ff;
	wire pop = out_ready && valid_ff;
	wire [AW:0] nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
	assign in_ready = ready_ff;
	assign out_valid = valid_ff;
	assign out_data = mem[rd_ptr_ff];
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			ready_ff <= 1'b1;
			valid_ff <= 1'b0;
		end else begin
			wr_ptr_ff <= wr_ptr_ff + AW'(push);
			rd_ptr_ff <= rd_ptr_ff + AW'(pop);
			count_ff <= nxt_count;
			ready_ff <= nxt_count != (AW+1)'(DEPTH);
			valid_ff <= nxt_count != '0;
		end
	end
endmodule : sod_fifo
`default_nettype wire

// ===== verilog/sod_char_timer.sv
/*
 Baud divider and character-time delay counter.
 Assumes baud_sel is stable while a delay runs; the bit tick feeds the serial transmitter.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sod_cfg.svh"
module sod_char_timer #(
	parameter int unsigned BASE_DIV = `SOD_BASE_DIV,
	parameter int unsigned CHAR_BITS = `SOD_CHAR_BITS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] baud_sel,
	input wire logic start,
	input wire logic [2:0] units,
	output logic bit_tick,
	output logic busy,
	output logic done
);
	generate
		if (BASE_DIV < 2 || CHAR_BITS < 1 || CHAR_BITS > 16) begin : g_chk
			$error("sod_char_timer needs BASE_DIV of two or more and 1..16 bits");
		end
	endgenerate
	logic [31:0] div_ff;
	logic [6:0] tick_cnt_ff;
	logic [6:0] tick_goal_ff;
	logic tick_ff;
	logic busy_ff;
	logic done_ff;
	wire [31:0] div_last = (32'(BASE_DIV) << baud_sel) - 32'h1;
	wire div_wrap = div_ff >= div_last;
	// One spare tick covers the partial bit at the start, keeping the delay a minimum.
	wire [6:0] goal = 7'(units) * 7'(CHAR_BITS) + 7'h1;
	wire reach = busy_ff && tick_ff && (tick_cnt_ff + 7'h1 == tick_goal_ff);
	assign bit_tick = tick_ff;
	assign busy = busy_ff;
	assign done = done_ff;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			div_ff <= div_wrap ? 32'h0 : div_ff + 32'h1;
			tick_ff <= div_wrap;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			tick_cnt_ff <= '0;
			tick_goal_ff <= '0;
		end else begin
			done_ff <= (start && units == 3'h0) || reach;
			if (start && units != 3'h0) begin
				busy_ff <= 1'b1;
				tick_cnt_ff <= '0;
				tick_goal_ff <= goal;
			end else if (reach) begin
				busy_ff <= 1'b0;
			end else if (busy_ff && tick_ff) begin
				tick_cnt_ff <= tick_cnt_ff + 7'h1;
			end
		end
	end
endmodule : sod_char_timer
`default_nettype wire

// ===== verilog/sod_setup_decoder.sv
/*
 Setup options decoder: holds setup bytes three and four, echoes received characters, ends
 commands, times the response turn-around, masks readback digits and decodes manual inputs.
 Assumes a UART outside that delivers and sends characters, and a command parser outside that
 issues setup writes, response requests and readback values.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sod_cfg.svh"
module sod_setup_decoder #(
	parameter int unsigned BASE_DIV = `SOD_BASE_DIV,
	parameter int unsigned FIFO_DEPTH = `SOD_FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	output logic cmd_valid,
	output logic [7:0] cmd_data,
	output logic cmd_end,
	input wire logic su_wr,
	input wire logic [7:0] su_b3,
	input wire logic [7:0] su_b4,
	input wire logic wr_enabled,
	output logic su_refused,
	input wire logic [2:0] baud_sel,
	output logic [7:0] comm_options_setup,
	output logic [7:0] display_manual_setup,
	input wire logic resp_req,
	output logic resp_go,
	output logic resp_wait,
	output logic bit_tick,
	input wire logic rb_valid,
	input wire logic rb_output_readback,
	input wire logic rb_sign,
	input wire logic [27:0] rb_digits,
	output logic rbo_valid,
	output logic rbo_sign,
	output logic [27:0] rbo_digits,
	input wire logic [2:0] gen_input,
	output logic [2:0] din_level,
	output logic cont_in_en,
	output logic limit_check_en,
	output logic echo_en,
	output logic manual_en,
	output logic [1:0] manual_mode,
	output logic slope_up,
	output logic slope_down,
	output logic hold_out,
	output logic up_limit,
	output logic down_limit
);
	logic [7:0] setup3_ff;
	logic [7:0] setup4_ff;
	localparam logic [7:0] B3_RST_V = `SOD_B3_RST;
	localparam logic [7:0] B4_RST_V = `SOD_B4_RST;
	logic su_refused_ff;
	logic lim_chk_ff;
	logic man_en_ff;
	logic tx_valid_ff;
	logic [7:0] tx_data_ff;
	logic cmd_valid_ff;
	logic [7:0] cmd_data_ff;
	logic cmd_end_ff;
	logic last_cr_ff;
	logic resp_go_ff;
	logic rbo_valid_ff;
	logic rbo_sign_ff;
	logic [27:0] rbo_digits_ff;
	logic [2:0] din_ff;
	logic slope_up_ff;
	logic slope_down_ff;
	logic hold_ff;
	logic up_lim_ff;
	logic down_lim_ff;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire timer_busy;
	wire timer_done;
	wire rx_take = rx_valid && fifo_in_ready;
	wire is_cr = rx_data == `SOD_ASCII_CR;
	wire drop_lf = (rx_data == `SOD_ASCII_LF) && last_cr_ff;
	wire su_accept = su_wr && wr_enabled;
	wire su_reject = su_wr && !wr_enabled;
	wire echo_on = setup3_ff[`SOD_B3_ECHO];
	wire fifo_pop = fifo_out_valid && (!tx_valid_ff || tx_ready);
	wire [2:0] delay_units = {setup3_ff[`SOD_B3_DLY_HI:`SOD_B3_DLY_LO], 1'b0};
	wire [1:0] digit_sel = setup4_ff[`SOD_B4_DIG_HI:`SOD_B4_DIG_LO];
	wire [1:0] zero_cnt = ~digit_sel;
	wire man_on = !setup4_ff[`SOD_B4_MANDIS];
	wire [1:0] mode = setup4_ff[`SOD_B4_MODE_HI:`SOD_B4_MODE_LO];
	wire dn_n = din_ff[0];
	wire up_n = din_ff[1];
	wire [27:0] masked;
	assign rx_ready = fifo_in_ready;
	assign tx_valid = tx_valid_ff;
	assign tx_data = tx_data_ff;
	assign cmd_valid = cmd_valid_ff;
	assign cmd_data = cmd_data_ff;
	assign cmd_end = cmd_end_ff;
	assign su_refused = su_refused_ff;
	assign comm_options_setup = setup3_ff;
	assign display_manual_setup = setup4_ff;
	assign resp_go = resp_go_ff;
	assign resp_wait = timer_busy;
	assign rbo_valid = rbo_valid_ff;
	assign rbo_sign = rbo_sign_ff;
	assign rbo_digits = rbo_digits_ff;
	assign din_level = din_ff;
	assign cont_in_en = setup3_ff[`SOD_B3_CONT];
	assign limit_check_en = lim_chk_ff;
	assign echo_en = echo_on;
	assign manual_en = man_en_ff;
	assign manual_mode = setup4_ff[`SOD_B4_MODE_HI:`SOD_B4_MODE_LO];
	assign slope_up = slope_up_ff;
	assign slope_down = slope_down_ff;
	assign hold_out = hold_ff;
	assign up_limit = up_lim_ff;
	assign down_limit = down_lim_ff;
	sod_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_echo_fifo (
		.clk(ref_clk),
		.rst(rst),
		.in_valid(rx_valid && echo_on),
		.in_data(rx_data),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(fifo_pop)
	);
	sod_char_timer #(
		.BASE_DIV(BASE_DIV),
		.CHAR_BITS(`SOD_CHAR_BITS)
	) u_timer (
		.clk(ref_clk),
		.rst(rst),
		.baud_sel(baud_sel),
		.start(resp_req),
		.units(delay_units),
		.bit_tick(bit_tick),
		.busy(timer_busy),
		.done(timer_done)
	);
	genvar gi;
	generate
		for (gi = 0; gi < `SOD_DIGITS; gi++) begin : g_mask
			assign masked[gi*4 +: 4] = (gi < 32'(zero_cnt)) ? 4'h0 : rb_digits[gi*4 +: 4];
		end
	endgenerate
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			setup3_ff <= `SOD_B3_RST;
			setup4_ff <= `SOD_B4_RST;
			su_refused_ff <= 1'b0;
			lim_chk_ff <= !B3_RST_V[`SOD_B3_LIMDIS];
			man_en_ff <= !B4_RST_V[`SOD_B4_MANDIS];
		end else begin
			su_refused_ff <= su_reject;
			if (su_accept) begin
				setup3_ff <= su_b3 & `SOD_B3_MASK;
				setup4_ff <= su_b4 & `SOD_B4_MASK;
				lim_chk_ff <= !su_b3[`SOD_B3_LIMDIS];
				man_en_ff <= !su_b4[`SOD_B4_MANDIS];
			end
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_valid_ff <= 1'b0;
			tx_data_ff <= 8'h00;
		end else if (fifo_pop) begin
			tx_valid_ff <= 1'b1;
			tx_data_ff <= fifo_out_data;
		end else if (tx_ready) begin
			tx_valid_ff <= 1'b0;
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmd_valid_ff <= 1'b0;
			cmd_data_ff <= 8'h00;
			cmd_end_ff <= 1'b0;
			last_cr_ff <= 1'b0;
		end else begin
			cmd_valid_ff <= rx_take && !drop_lf;
			cmd_end_ff <= rx_take && is_cr;
			if (rx_take) begin
				cmd_data_ff <= rx_data;
				last_cr_ff <= is_cr;
			end
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			resp_go_ff <= 1'b0;
		end else begin
			resp_go_ff <= timer_done;
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rbo_valid_ff <= 1'b0;
			rbo_sign_ff <= 1'b0;
			rbo_digits_ff <= '0;
		end else begin
			rbo_valid_ff <= rb_valid;
			if (rb_valid) begin
				rbo_sign_ff <= rb_sign;
				rbo_digits_ff <= rb_output_readback ? masked : rb_digits;
			end
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			din_ff <= `SOD_DIN_RST;
		end else begin
			din_ff <= gen_input;
		end
	end
	wire lim_hold = (mode == sod_pkg::SOD_MAN_LIM_NO) ? (!dn_n && !up_n) : (dn_n && up_n);
	wire lim_up = (mode == sod_pkg::SOD_MAN_LIM_NO) ? (dn_n && !up_n) : (!dn_n && up_n);
	wire lim_dn = (mode == sod_pkg::SOD_MAN_LIM_NO) ? (!dn_n && up_n) : (dn_n && !up_n);
	wire is_lim = mode[1];
	wire nxt_up = man_on && ((mode == sod_pkg::SOD_MAN_UPDOWN && !up_n && dn_n)
		|| (mode == sod_pkg::SOD_MAN_CTRL && !dn_n && !up_n));
	wire nxt_dn = man_on && ((mode == sod_pkg::SOD_MAN_UPDOWN && up_n && !dn_n)
		|| (mode == sod_pkg::SOD_MAN_CTRL && !dn_n && up_n));
	wire nxt_hold = man_on && ((mode == sod_pkg::SOD_MAN_UPDOWN && !up_n && !dn_n)
		|| (is_lim && lim_hold));
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			slope_up_ff <= 1'b0;
			slope_down_ff <= 1'b0;
			hold_ff <= 1'b0;
			up_lim_ff <= 1'b0;
			down_lim_ff <= 1'b0;
		end else begin
			slope_up_ff <= nxt_up;
			slope_down_ff <= nxt_dn;
			hold_ff <= nxt_hold;
			up_lim_ff <= man_on && is_lim && (lim_up || lim_hold);
			down_lim_ff <= man_on && is_lim && (lim_dn || lim_hold);
		end
	end
	echo_push_a: assert property (@(posedge ref_clk) disable iff (rst)
		(rx_take && echo_on) |=> (fifo_out_valid || tx_valid_ff))
		else $error("echoed character lost");
	lf_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
		(rx_take && drop_lf) |=> !cmd_valid_ff)
		else $error("linefeed after carriage return passed on");
	cr_end_a: assert property (@(posedge ref_clk) disable iff (rst)
		(rx_take && is_cr) |=> (cmd_valid_ff && cmd_end_ff))
		else $error("carriage return did not end command");
	su_refuse_a: assert property (@(posedge ref_clk) disable iff (rst)
		su_reject |=> (su_refused_ff && $stable(setup3_ff) && $stable(setup4_ff)))
		else $error("protected setup write not refused");
	cont_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
		su_accept |=> (cont_in_en == $past(su_b3[5])))
		else $error("continuous input enable wrong");
	limit_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
		su_accept |=> (limit_check_en == !$past(su_b3[4])))
		else $error("limit check enable wrong");
	delay_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
		(resp_req && delay_units == 3'h0 && !timer_busy) |-> ##2 resp_go_ff)
		else $error("zero delay response not granted");
	delay_min_a: assert property (@(posedge ref_clk) disable iff (rst)
		(resp_req && delay_units != 3'h0) |=> (!resp_go_ff) [*8])
		else $error("response granted before delay");
	mask_three_a: assert property (@(posedge ref_clk) disable iff (rst)
		(rb_valid && rb_output_readback && digit_sel == 2'b00) |=> rbo_digits_ff[11:0] == 12'h000)
		else $error("three trailing digits not zeroed");
	mask_other_a: assert property (@(posedge ref_clk) disable iff (rst)
		(rb_valid && !rb_output_readback) |=> rbo_digits_ff == $past(rb_digits))
		else $error("non readback data altered");
	man_off_a: assert property (@(posedge ref_clk) disable iff (rst)
		$past(setup4_ff[2]) |-> !(slope_up_ff || slope_down_ff || hold_ff || up_lim_ff))
		else $error("manual action while disabled");
	updown_a: assert property (@(posedge ref_clk) disable iff (rst)
		(man_on && mode == 2'b00 && din_ff == 3'h1) |=> (slope_up_ff && !slope_down_ff))
		else $error("up input did not slope up");
	echo_c: cover property (@(posedge ref_clk) disable iff (rst) tx_valid_ff && tx_ready);
	grant_c: cover property (@(posedge ref_clk) disable iff (rst) timer_busy ##1 resp_go_ff);
	refuse_c: cover property (@(posedge ref_clk) disable iff (rst) su_refused_ff);
	masked_c: cover property (@(posedge ref_clk) disable iff (rst)
		rb_valid && rb_output_readback && digit_sel != 2'b11);
endmodule : sod_setup_decoder
`default_nettype wire

// ===== bench/sod_host_model.sv
/*
 Serial host model: offers received characters and takes echoed ones, stalling at random.
 Assumes the bench calls send_char and idle, sets stall, and reads echo_q and refusals.
*/
`timescale 1ns/1ps
`default_nettype none
module sod_host_model (
	input wire logic clk,
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready
);
	logic [7:0] echo_q[$];
	logic stall;
	int refusals;
	integer seed;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
		stall = 1'b1;
		refusals = 0;
		seed = 32'h594910a1;
	end
	// A released data line must not look like the last character, so it toggles.
	always @(posedge clk) begin
		if (!rx_valid) rx_data <= ~rx_data;
	end
	always @(negedge clk) begin
		tx_ready = !stall && (($random(seed) & 3) != 0);
		if (tx_valid && tx_ready) echo_q.push_back(tx_data);
	end
	task automatic send_char(input logic [7:0] c);
		logic taken;
		int n;
		taken = 1'b0;
		n = 0;
		while (!taken && n < 200) begin
			@(negedge clk);
			rx_valid = 1'b1;
			rx_data = c;
			taken = rx_ready;
			if (!taken) refusals++;
			n++;
		end
	endtask : send_char
	task automatic idle();
		@(negedge clk);
		rx_valid = 1'b0;
	endtask : idle
endmodule : sod_host_model
`default_nettype wire

// ===== bench/tb_top.sv
/*
 Self-checking bench of the setup options decoder with a serial host model.
 Assumes a 200 MHz clock and a short bit divisor so delays stay brief.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sod_cfg.svh"
module tb_top;
	logic ref_clk, rst, rx_valid, rx_ready, tx_valid, tx_ready, cmd_valid, cmd_end, su_wr;
	logic wr_enabled, su_refused, resp_req, resp_go, resp_wait, bit_tick, rb_valid, rbr;
	logic rb_sign, rbo_valid, rbo_sign, cont_in_en, limit_check_en, echo_en, manual_en;
	logic slope_up, slope_down, hold_out, up_limit, down_limit;
	logic [7:0] rx_data, tx_data, cmd_data, su_b3, su_b4, cos, dms, m3, m4;
	logic [2:0] baud_sel, gen_input, din_level;
	logic [1:0] manual_mode;
	logic [27:0] rb_digits, rbo_digits;
	logic [8:0] cmd_q[$];
	logic [7:0] exp_echo[$];
	logic [8:0] exp_cmd[$];
	int bad_count, tests_run, n, u, lo, hi, w, t;
	integer seed;
	sod_setup_decoder #(.BASE_DIV(4)) dut_u (.ref_clk(ref_clk), .rst(rst), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_end(cmd_end),
		.su_wr(su_wr), .su_b3(su_b3), .su_b4(su_b4), .wr_enabled(wr_enabled),
		.su_refused(su_refused), .baud_sel(baud_sel), .comm_options_setup(cos),
		.display_manual_setup(dms), .resp_req(resp_req), .resp_go(resp_go),
		.resp_wait(resp_wait), .bit_tick(bit_tick), .rb_valid(rb_valid),
		.rb_output_readback(rbr), .rb_sign(rb_sign), .rb_digits(rb_digits),
		.rbo_valid(rbo_valid), .rbo_sign(rbo_sign), .rbo_digits(rbo_digits),
		.gen_input(gen_input), .din_level(din_level), .cont_in_en(cont_in_en),
		.limit_check_en(limit_check_en), .echo_en(echo_en), .manual_en(manual_en),
		.manual_mode(manual_mode), .slope_up(slope_up), .slope_down(slope_down),
		.hold_out(hold_out), .up_limit(up_limit), .down_limit(down_limit));
	sod_host_model host_u (.clk(ref_clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
	always #2.5 ref_clk = ~ref_clk;
	always @(negedge ref_clk) begin
		if (cmd_valid === 1'b1) cmd_q.push_back({cmd_end, cmd_data});
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp
	task automatic stop_test();
		if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	function automatic logic [4:0] man_exp(input logic [7:0] b4, input logic [2:0] g);
		logic up, dn;
		up = g[1];
		dn = g[0];
		if (b4[2]) return 5'b00000;
		case (b4[1:0])
			2'b00: return (!up && !dn) ? 5'b00100 : !up ? 5'b10000 : !dn ? 5'b01000 : 5'b0;
			2'b01: return dn ? 5'b00000 : !up ? 5'b10000 : 5'b01000;
			2'b10: return (!dn && !up) ? 5'b00111 : !dn ? 5'b00001 : !up ? 5'b00010 : 5'b0;
			default: return (dn && up) ? 5'b00111 : !dn && up ? 5'b00010 : dn ? 5'b00001 : 5'b0;
		endcase
	endfunction : man_exp
	task automatic setup(input logic [7:0] b3, input logic [7:0] b4, input logic en);
		logic refd;
		@(negedge ref_clk);
		su_b3 = b3;
		su_b4 = b4;
		wr_enabled = en;
		su_wr = 1'b1;
		@(negedge ref_clk);
		refd = su_refused;
		su_wr = 1'b0;
		@(negedge ref_clk);
		@(negedge ref_clk);
		if (en) begin
			m3 = b3 & `SOD_B3_MASK;
			m4 = b4 & `SOD_B4_MASK;
		end
		cmp(refd, !en, "refused");
		cmp({cos, dms}, {m3, m4}, "setup bytes");
		cmp({cont_in_en, limit_check_en, echo_en}, {m3[5], !m3[4], m3[2]}, "byte3");
		cmp({manual_en, manual_mode}, {!m4[2], m4[1:0]}, "byte4");
	endtask : setup
	task automatic send_all(input logic [7:0] s[$]);
		foreach (s[i]) host_u.send_char(s[i]);
		host_u.idle();
	endtask : send_all
	initial begin
		#100000;
		bad_count++;
		$display("mismatch t=%0t watchdog", $time);
		stop_test();
	end
	initial begin
		{ref_clk, su_wr, wr_enabled, resp_req, rb_valid, rbr, rb_sign} = 7'h00;
		{su_b3, su_b4, baud_sel, gen_input, rb_digits} = 0;
		rst = 1'b1;
		m3 = 8'h01;
		m4 = 8'h80;
		seed = 32'h594910a1;
		bad_count = 0;
		tests_run = 0;
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		cmp({cos, dms, din_level}, {8'h01, 8'h80, 3'h7}, "reset");
		setup(8'h37, 8'h43, 1'b0);
		for (int m = 0; m < 8; m++) begin
			setup($random(seed), ($random(seed) & 8'h38) | (m << 6) | m, 1'b1);
			for (int g = 0; g < 8; g++) begin
				@(negedge ref_clk);
				gen_input = g;
				repeat (2) @(negedge ref_clk);
				cmp(din_level, g, "din");
				cmp({slope_up, slope_down, hold_out, up_limit, down_limit}, man_exp(m4, g),
					"manual");
			end
			for (int r = 0; r < 2; r++) begin
				@(negedge ref_clk);
				rb_valid = 1'b1;
				rbr = r;
				rb_sign = $random(seed);
				rb_digits = $random(seed);
				@(negedge ref_clk);
				n = r ? 4 * (3 - m4[7:6]) : 0;
				cmp({rbo_valid, rbo_sign}, {1'b1, rb_sign}, "rb flags");
				cmp(rbo_digits, rb_digits & ~((28'h1 << n) - 28'h1), "rb digits");
				rb_valid = 1'b0;
			end
		end
		for (int b = 0; b < 2; b++) begin
			for (int f = 0; f < 4; f++) begin
				baud_sel = b;
				setup(f, m4, 1'b1);
				@(negedge ref_clk);
				resp_req = 1'b1;
				n = 0;
				w = 0;
				t = 0;
				do begin
					@(negedge ref_clk);
					resp_req = 1'b0;
					n++;
					if (resp_wait === 1'b1) w++;
					if (bit_tick === 1'b1) t++;
				end while (resp_go !== 1'b1 && n < 2000);
				u = 2 * f;
				lo = u == 0 ? 2 : u * 10 * (4 << b) + 3;
				hi = u == 0 ? 2 : (u * 10 + 1) * (4 << b) + 2;
				cmp(n >= lo && n <= hi, 1, "delay");
				cmp(w, u == 0 ? 0 : n - 2, "wait span");
				if (u != 0) cmp(t, u * 10 + 1, "char ticks");
			end
		end
		setup(8'h04, m4, 1'b1);
		cmd_q.delete();
		fork
			send_all('{8'h41, 8'h0d, 8'h0a, 8'h0a, 8'h42, 8'h43, 8'h44});
			begin
				repeat (40) @(negedge ref_clk);
				host_u.stall = 1'b0;
			end
		join
		repeat (60) @(negedge ref_clk);
		cmp(host_u.refusals > 0, 1, "fifo full");
		exp_echo = '{8'h41, 8'h0d, 8'h0a, 8'h0a, 8'h42, 8'h43, 8'h44};
		exp_cmd = '{9'h041, 9'h10d, 9'h00a, 9'h042, 9'h043, 9'h044};
		cmp(host_u.echo_q == exp_echo, 1, "echo");
		cmp(cmd_q == exp_cmd, 1, "cmd");
		setup(8'h00, m4, 1'b1);
		send_all('{8'h46});
		repeat (20) @(negedge ref_clk);
		cmp(host_u.echo_q.size(), 7, "no echo");
		cmp(cmd_q.size(), 7, "cmd count");
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
